// ### bench/host_model.sv
// host side model: streams argument characters into the core
// assumes the bench calls send_arg between commands, same clock as the core
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock
  input wire logic clk_i,
  // character stream
  output logic ch_valid_o,
  output logic [7:0] ch_o
);
  initial begin
    ch_valid_o = 1'b0;
    ch_o = 8'h00;
  end

  // one char per cycle, then idle long enough for the argument to latch
  task automatic send_arg(input string s);
    for (int i = 0; i < s.len() && i < 253; i++) begin
      @(posedge clk_i);
      ch_valid_o <= 1'b1;
      ch_o <= s[i];
    end
    @(posedge clk_i);
    ch_valid_o <= 1'b0;
    ch_o <= ~ch_o; // released line shows no stale char
    repeat (3) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### bench/test_instrument_trigger_command_parser.sv
// self-checking bench for the trigger command core
// assumes host_model for arguments; commands driven here
`timescale 1ns/10ps
`default_nettype none
module test_instrument_trigger_command_parser;
  import trig_cmd_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ch_valid, cmd_valid, cmd_ready_o, resp_valid_o, resp_neg_o, resp_is_int_o;
  logic resp_int_o, resp_last_o, err_valid_o, trig_pulse_o;
  logic [7:0] ch, err_code_o;
  op_t cmd_op = OP_NONE;
  kw_t cmd_kw = KW_NONE;
  logic [40:0] lim_pos = 41'h0_2540_BE40, vprot_pos_o, vprot_neg_o;
  logic [15:0] oper_cond_o, oper_event_o;
  logic [41:0] volt_set_o, curr_set_o;
  logic [6:0] meas_rate_o;
  logic [47:0] meas_volt = 48'h0000_0000_0000;
  logic [47:0] meas_curr = 48'h0000_0499_0000;
  logic [40:0] lim_neg = 41'h0_1DCD_6500;
  logic ext_trig = 1'b0, oper_evt_clr = 1'b0;
  logic [3:0] tran_count = 4'h0;
  logic [7:0][47:0] tran_smp = '0;
  logic [19:0] resp_mant_o;
  logic [4:0] resp_exp_o;
  logic seen_r, seen_e, seen_t, seen_i, seen_l;
  int failures = 0, check_count = 0;
  initial cmd_valid = 1'b0;
  always #20 clk_i = ~clk_i;

  host_model host (.clk_i(clk_i), .ch_valid_o(ch_valid), .ch_o(ch));
  trig_cmd_core dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ch_valid_i(ch_valid), .ch_i(ch),
    .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_kw_i(cmd_kw), .cmd_ready_o(cmd_ready_o),
    .lim_pos_i(lim_pos), .lim_neg_i(lim_neg), .ext_trig_i(ext_trig),
    .oper_en_i(16'h0020), .oper_evt_clr_i(oper_evt_clr), .oper_cond_o(oper_cond_o),
    .oper_event_o(oper_event_o), .volt_set_o(volt_set_o), .curr_set_o(curr_set_o),
    .vprot_pos_o(vprot_pos_o), .vprot_neg_o(vprot_neg_o), .trig_pulse_o(trig_pulse_o),
    .meas_rate_o(meas_rate_o), .meas_volt_i(meas_volt), .meas_volt_neg_i(1'b0),
    .meas_curr_i(meas_curr), .meas_curr_neg_i(1'b1), .tran_sample_i(tran_smp),
    .tran_neg_i(8'h00),
    .tran_count_i(tran_count), .resp_valid_o(resp_valid_o), .resp_mant_o(resp_mant_o),
    .resp_exp_o(resp_exp_o), .resp_neg_o(resp_neg_o), .resp_is_int_o(resp_is_int_o),
    .resp_int_o(resp_int_o), .resp_last_o(resp_last_o), .err_valid_o(err_valid_o),
    .err_code_o(err_code_o)
  );

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // one command, then collect the one-cycle pulses for four cycles
  task automatic cmd(input op_t op, input kw_t kw);
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 8) begin
      failures++;
      results();
    end
    @(posedge clk_i);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_kw <= kw;
    @(posedge clk_i);
    cmd_valid <= 1'b0;
    {seen_r, seen_e, seen_t, seen_i, seen_l} = 5'b00000;
    repeat (4) begin
      #1;
      seen_r |= (resp_valid_o === 1'b1);
      seen_i |= (resp_valid_o === 1'b1 && resp_is_int_o === 1'b1);
      seen_l |= (resp_last_o === 1'b1);
      seen_e |= (err_valid_o === 1'b1);
      seen_t |= (trig_pulse_o === 1'b1);
      @(posedge clk_i);
    end
  endtask

  // single arm: digit truncation, one trigger only, bad value kept out
  task automatic t_single();
    host.send_arg("0\n");
    cmd(OP_SOUR, KW_NONE);
    host.send_arg("12345.123456789\n");
    cmd(OP_VTRIG, KW_NONE);
    cmd(OP_INIT, KW_NONE);
    chk(oper_cond_o[WTG_BIT], 1'b1);
    cmd(OP_TRG, KW_NONE);
    chk(seen_t, 1'b1);
    chk(volt_set_o, 42'd234512345678);
    cmd(OP_TRG, KW_NONE);
    chk(seen_t, 1'b0);
    host.send_arg("7000\n");
    cmd(OP_VTRIG, KW_NONE);
    chk({seen_e, err_code_o}, {1'b1, ERR_NUMERIC});
    cmd(OP_INIT, KW_NONE);
    cmd(OP_ABORT, KW_NONE);
    chk(oper_cond_o[WTG_BIT], 1'b0);
    cmd(OP_TRG, KW_NONE);
    chk(seen_t, 1'b0);
    cmd(OP_INIT, KW_NONE);
    cmd(OP_TRG, KW_NONE);
    chk(volt_set_o, 42'd234512345678);
  endtask

  // keywords: user limit for max, protection full scale plus one percent
  task automatic t_keyword();
    cmd(OP_VTRIG, KW_MAX);
    cmd(OP_CTRIG, KW_MIN);
    cmd(OP_INIT, KW_NONE);
    cmd(OP_TRG, KW_NONE);
    chk(volt_set_o, {1'b0, lim_pos});
    chk(curr_set_o, {1'b1, lim_neg});
    cmd(OP_VPROT, KW_MAX);
    chk(vprot_pos_o, 41'h2_5A01_C500);
    chk(vprot_neg_o, 41'h2_5A01_C500);
  endtask

  // every legal rate, then an illegal one that must not stick
  task automatic t_rate();
    logic [6:0] r[3] = '{RATE_50, RATE_125, RATE_60};
    foreach (r[i]) begin
      host.send_arg($sformatf("%0d\n", r[i]));
      cmd(OP_RATE, KW_NONE);
      chk(meas_rate_o, r[i]);
    end
    host.send_arg("70\n");
    cmd(OP_RATE, KW_NONE);
    chk({seen_e, meas_rate_o}, {1'b1, RATE_60});
  endtask

  // continuous arming with bus source, abort, reset command
  task automatic t_cont();
    host.send_arg("1\n");
    cmd(OP_CONT, KW_NONE);
    cmd(OP_CONTQ, KW_NONE);
    chk({seen_r, seen_i, resp_int_o}, 3'b111);
    chk(oper_cond_o, 16'h0020);
    cmd(OP_ABORT, KW_NONE);
    chk(oper_cond_o[WTG_BIT], 1'b1);
    cmd(OP_TRG, KW_NONE);
    chk({seen_t, oper_cond_o[WTG_BIT]}, 2'b11);
    cmd(OP_RST, KW_NONE);
    chk(oper_cond_o[WTG_BIT], 1'b0);
    cmd(OP_CONTQ, KW_NONE);
    chk(resp_int_o, 1'b0);
  endtask

  // continuous external: bus trigger ignored, pin edge drops the flag one cycle
  task automatic t_ext();
    host.send_arg("1\n");
    cmd(OP_SOUR, KW_NONE);
    host.send_arg("1\n");
    cmd(OP_CONT, KW_NONE);
    cmd(OP_TRG, KW_NONE);
    chk(seen_t, 1'b0);
    oper_evt_clr <= 1'b1;
    @(posedge clk_i);
    oper_evt_clr <= 1'b0;
    ext_trig <= 1'b1;
    @(posedge clk_i);
    #1;
    chk({oper_event_o[WTG_BIT], oper_cond_o[WTG_BIT]}, 2'b01);
    // three filter flops, then one cycle for the registered pulse
    repeat (3) @(posedge clk_i);
    #1;
    chk({trig_pulse_o, oper_cond_o[WTG_BIT]}, 2'b10);
    @(posedge clk_i);
    ext_trig <= 1'b0;
    #1;
    chk({oper_event_o[WTG_BIT], oper_cond_o[WTG_BIT]}, 2'b11);
  endtask

  // transient readback: three samples in index order, commands held off
  task automatic t_tran();
    logic [24:0] e[3] = '{{20'h1_5003, 5'h00}, {20'h5_0003, 5'h00}, {20'h4_9900, 5'h1E}};
    tran_smp[0] <= 48'h0001_5003_0000;
    tran_smp[1] <= 48'h0005_0003_0000;
    tran_smp[2] <= 48'h0000_0499_0000;
    tran_count <= 4'h3;
    @(posedge clk_i);
    cmd_valid <= 1'b1;
    cmd_op <= OP_MTRAN;
    @(posedge clk_i);
    cmd_valid <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      #1;
      chk({cmd_ready_o, resp_valid_o, resp_last_o}, {k == 2, 1'b1, k == 2});
      chk({resp_mant_o, resp_exp_o}, e[k]);
    end
    @(posedge clk_i);
  endtask

  // sensed 20.99 V as 2.0990 exponent 1, sensed -0.0499 A as 4.9900 exponent -2
  task automatic t_meas();
    meas_volt <= 48'h0020_9900_0000;
    cmd(OP_MVOLT, KW_NONE);
    chk({seen_r, seen_l, resp_neg_o, resp_mant_o, resp_exp_o}, {3'b110, 20'h2_0990, 5'h01});
    cmd(OP_MCURR, KW_NONE);
    chk({seen_r, resp_neg_o, resp_mant_o, resp_exp_o}, {2'b11, 20'h4_9900, 5'h1E});
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk({meas_rate_o, oper_cond_o}, {RATE_60, 16'h0000});
    t_single();
    t_keyword();
    t_rate();
    t_cont();
    t_ext();
    t_tran();
    t_meas();
    results();
  end
endmodule
`default_nettype wire

// ### rtl/num_arg_if.sv
// carries one parsed numeric argument from the parser to the core
// assumes both ends sit on the same clock
`timescale 1ns/10ps
`default_nettype none
interface num_arg_if;
  logic valid;
  logic neg;
  logic [40:0] mag;
  logic range_err;
  logic len_err;
  modport src (output valid, neg, mag, range_err, len_err);
  modport dst (input valid, neg, mag, range_err, len_err);
endinterface
`default_nettype wire

// ### rtl/num_arg_parser.sv
// decimal argument parser: characters in, fixed point magnitude out
// assumes one character per strobe, line feed ends the argument
`timescale 1ns/10ps
`default_nettype none
module num_arg_parser
  import trig_cmd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // character stream
  input wire logic ch_valid_i,
  input wire logic [7:0] ch_i,
  // parsed argument
  num_arg_if.src arg
);
  import trig_cmd_pkg::*;

  typedef struct packed {
    logic [15:0] int_bcd;
    logic [31:0] frac_bcd;
    logic [3:0] frac_n;
    logic seen_pt;
    logic neg;
    logic [7:0] len;
    logic valid;
    logic vneg;
    logic [40:0] mag;
    logic range_err;
    logic len_err;
  } pst_t;

  pst_t q, d;
  logic [40:0] mag_n;

  // digits accumulate most significant first
  function automatic logic [40:0] bcd_to_mag(input logic [47:0] b);
    logic [40:0] acc;
    acc = '0;
    for (int k = 11; k >= 0; k--) begin
      acc = 41'(acc * DEC_BASE + {37'h0, b[4*k +: 4]});
    end
    return acc;
  endfunction

  assign mag_n = bcd_to_mag({q.int_bcd, q.frac_bcd});

  // next state of the parser
  always_comb begin
    d = q;
    d.valid = 1'b0;
    if (ch_valid_i) begin
      if (ch_i == CH_END) begin
        d.valid = 1'b1;
        d.vneg = q.neg;
        d.mag = mag_n;
        d.range_err = (mag_n > MAG_MAX) || ((mag_n != '0) && (mag_n < MAG_MIN));
        d.len_err = (q.len >= MAX_STR_LEN);
        d.int_bcd = '0;
        d.frac_bcd = '0;
        d.frac_n = '0;
        d.seen_pt = 1'b0;
        d.neg = 1'b0;
        d.len = '0;
      end else begin
        if (q.len != LEN_SAT) begin
          d.len = q.len + 8'h01;
        end
        // characters past the buffer limit are dropped, not stored
        if (q.len < MAX_STR_LEN) begin
          if (ch_i >= CH_0 && ch_i <= CH_9) begin
            if (!q.seen_pt) begin
              d.int_bcd = {q.int_bcd[11:0], ch_i[3:0]}; // leading digits fall off
            end else if (q.frac_n < 4'(FRAC_DIGITS)) begin
              d.frac_bcd[31 - 4*q.frac_n -: 4] = ch_i[3:0];
              d.frac_n = q.frac_n + 4'h1;
            end
          end else if (ch_i == CH_PT) begin
            d.seen_pt = 1'b1;
          end else if (ch_i == CH_MINUS) begin
            d.neg = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign arg.valid = q.valid;
  assign arg.neg = q.vneg;
  assign arg.mag = q.mag;
  assign arg.range_err = q.range_err;
  assign arg.len_err = q.len_err;

  AST_FRAC_LIMIT:
  assert property (@(posedge clk_i) disable iff (sys_rst_i)
    q.frac_n <= 4'(FRAC_DIGITS)) else $error("fraction digit count above eight");

  AST_LONG_FLAG:
  assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ch_valid_i && ch_i == CH_END && q.len >= MAX_STR_LEN |=> arg.valid && arg.len_err)
    else $error("over-long argument not flagged");

endmodule
`default_nettype wire

// ### rtl/trig_cmd_core.sv
// trigger and measurement command core of a bipolar source front end
// assumes commands arrive decoded, arguments come through the parser
`timescale 1ns/10ps
`default_nettype none
module trig_cmd_core
  import trig_cmd_pkg::*;
#(
  parameter logic [40:0] FS_VOLT = 41'h2_540B_E400 // full-scale voltage, 100 V
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // argument characters
  input wire logic ch_valid_i,
  input wire logic [7:0] ch_i,
  // decoded command
  input wire logic cmd_valid_i,
  input wire trig_cmd_pkg::op_t cmd_op_i,
  input wire trig_cmd_pkg::kw_t cmd_kw_i,
  output logic cmd_ready_o,
  // user limits for keywords
  input wire logic [40:0] lim_pos_i,
  input wire logic [40:0] lim_neg_i,
  // external trigger pin
  input wire logic ext_trig_i,
  // status
  input wire logic [15:0] oper_en_i,
  input wire logic oper_evt_clr_i,
  output logic [15:0] oper_cond_o,
  output logic [15:0] oper_event_o,
  // output programming
  output logic [41:0] volt_set_o,
  output logic [41:0] curr_set_o,
  output logic [40:0] vprot_pos_o,
  output logic [40:0] vprot_neg_o,
  output logic trig_pulse_o,
  output logic [6:0] meas_rate_o,
  // measurement inputs, bcd 4.8 digits
  input wire logic [47:0] meas_volt_i,
  input wire logic meas_volt_neg_i,
  input wire logic [47:0] meas_curr_i,
  input wire logic meas_curr_neg_i,
  input wire logic [7:0][47:0] tran_sample_i,
  input wire logic [7:0] tran_neg_i,
  input wire logic [3:0] tran_count_i,
  // responses
  output logic resp_valid_o,
  output logic [19:0] resp_mant_o,
  output logic [4:0] resp_exp_o,
  output logic resp_neg_o,
  output logic resp_is_int_o,
  output logic resp_int_o,
  output logic resp_last_o,
  // errors
  output logic err_valid_o,
  output logic [7:0] err_code_o
);
  import trig_cmd_pkg::*;

  localparam logic [40:0] VPROT_FS = 41'(FS_VOLT + FS_VOLT / 41'h0064);
  localparam logic [40:0] RATE_50_MAG = 41'(MAG_SCALE * RATE_50);
  localparam logic [40:0] RATE_60_MAG = 41'(MAG_SCALE * RATE_60);
  localparam logic [40:0] RATE_125_MAG = 41'(MAG_SCALE * RATE_125);

  typedef struct packed {
    logic [19:0] mant;
    logic [4:0] exp;
  } sci_t;

  typedef struct packed {
    fsm_t fsm;
    logic src_ext;
    logic wtg;
    logic evt_wtg;
    num_t vtrig;
    num_t ctrig;
    num_t volt_set;
    num_t curr_set;
    logic [40:0] vprot_pos;
    logic [40:0] vprot_neg;
    logic [6:0] rate;
    logic trig_pulse;
    logic arg_have;
    num_t arg;
    logic arg_bad;
    logic arg_long;
    logic [2:0] ext_sync;
    logic ext_lvl;
    logic tran_busy;
    logic [3:0] tran_idx;
    logic resp_valid;
    logic [19:0] resp_mant;
    logic [4:0] resp_exp;
    logic resp_neg;
    logic resp_is_int;
    logic resp_int;
    logic resp_last;
    logic err_valid;
    logic [7:0] err_code;
  } st_t;

  st_t q, d;
  num_arg_if arg_bus ();
  logic take;
  logic ext_lvl_n;
  logic ext_rise;
  logic fire;
  logic val_ok;
  num_t val;
  logic [7:0] val_err;

  // normalise a bcd fixed point value to mantissa and exponent
  function automatic sci_t to_sci(input logic [47:0] b);
    sci_t r;
    int lead;
    logic [79:0] ext;
    r = '0;
    lead = 12;
    ext = {b, 32'h0};
    // scan upward so the most significant nonzero digit is the one kept
    for (int i = 0; i <= 11; i++) begin
      if (b[4*i +: 4] != 4'h0) begin
        lead = 11 - i;
      end
    end
    if (lead < 12) begin
      ext = ext << (4 * lead);
      r.mant = ext[79:60];
      r.exp = EXP_LEAD - 5'(lead);
    end
    return r;
  endfunction

  num_arg_parser u_parser (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ch_valid_i(ch_valid_i),
    .ch_i(ch_i),
    .arg(arg_bus.src)
  );

  // transient readback holds off new commands while it streams
  assign cmd_ready_o = !q.tran_busy;
  assign take = cmd_valid_i && cmd_ready_o;

  // pin filter: third stage must agree with second before a change counts
  assign ext_lvl_n = (q.ext_sync[1] == q.ext_sync[2]) ? q.ext_sync[1] : q.ext_lvl;
  assign ext_rise = ext_lvl_n && !q.ext_lvl;

  // bus trigger only counts with bus source, pin only with external source
  assign fire = ((take && cmd_op_i == OP_TRG && !q.src_ext)
                 || (ext_rise && q.src_ext)) && (q.fsm != ST_IDLE);

  // keywords replace the latched argument
  always_comb begin
    val = q.arg;
    val_ok = q.arg_have && !q.arg_bad && !q.arg_long;
    val_err = !q.arg_have ? ERR_MISSING : (q.arg_long ? ERR_TOO_LONG : ERR_NUMERIC);
    if (cmd_kw_i == KW_MAX) begin
      val = '{neg: 1'b0, mag: lim_pos_i};
      val_ok = 1'b1;
    end else if (cmd_kw_i == KW_MIN) begin
      val = '{neg: 1'b1, mag: lim_neg_i};
      val_ok = 1'b1;
    end
  end

  // next state of the whole core
  always_comb begin
    d = q;
    d.resp_valid = 1'b0;
    d.resp_last = 1'b0;
    d.resp_is_int = 1'b0;
    d.err_valid = 1'b0;
    d.trig_pulse = 1'b0;
    d.ext_sync = {q.ext_sync[1:0], ext_trig_i};
    d.ext_lvl = ext_lvl_n;
    // an argument is used once; a fresh one in the same cycle still lands
    if (take && cmd_op_i inside {OP_VTRIG, OP_CTRIG, OP_CONT, OP_SOUR, OP_RATE, OP_VPROT}) begin
      d.arg_have = 1'b0;
    end
    if (arg_bus.valid) begin
      d.arg_have = 1'b1;
      d.arg = '{neg: arg_bus.neg, mag: arg_bus.mag};
      d.arg_bad = arg_bus.range_err;
      d.arg_long = arg_bus.len_err;
    end
    // trigger applies the stored levels
    if (fire) begin
      d.volt_set = q.vtrig;
      d.curr_set = q.ctrig;
      d.trig_pulse = 1'b1;
      if (q.fsm == ST_ARMED) begin
        d.fsm = ST_IDLE;
      end
    end
    if (take) begin
      case (cmd_op_i)
        OP_VTRIG, OP_CTRIG: begin
          if (!val_ok) begin
            d.err_valid = 1'b1; // setting keeps its old value
            d.err_code = val_err;
          end else if (cmd_op_i == OP_VTRIG) begin
            d.vtrig = val;
          end else begin
            d.ctrig = val;
          end
        end
        OP_ABORT: begin
          if (q.fsm == ST_ARMED) begin
            d.fsm = ST_IDLE; // continuous falls through untouched
          end
        end
        OP_INIT: begin
          if (d.fsm == ST_IDLE) begin
            d.fsm = ST_ARMED; // redundant while continuous
          end
        end
        OP_CONT: begin
          if (val_ok) begin
            d.fsm = (val.mag != '0) ? ST_CONT : ST_IDLE;
          end else begin
            d.err_valid = 1'b1;
            d.err_code = val_err;
          end
        end
        OP_CONTQ: begin
          d.resp_valid = 1'b1;
          d.resp_is_int = 1'b1;
          d.resp_int = (q.fsm == ST_CONT);
          d.resp_last = 1'b1;
        end
        OP_SOUR: begin
          if (val_ok) begin
            d.src_ext = (val.mag != '0);
          end else begin
            d.err_valid = 1'b1;
            d.err_code = val_err;
          end
        end
        OP_RATE: begin
          // only the three rates are legal; anything else keeps the old one
          if (val_ok && !val.neg && val.mag == RATE_50_MAG) begin
            d.rate = RATE_50;
          end else if (val_ok && !val.neg && val.mag == RATE_60_MAG) begin
            d.rate = RATE_60;
          end else if (val_ok && !val.neg && val.mag == RATE_125_MAG) begin
            d.rate = RATE_125;
          end else begin
            d.err_valid = 1'b1;
            d.err_code = val_ok ? ERR_NUMERIC : val_err;
          end
        end
        OP_MVOLT, OP_MCURR: begin
          // sensed values only, the programmed levels never reach here
          d.resp_valid = 1'b1;
          d.resp_last = 1'b1;
          {d.resp_mant, d.resp_exp} = to_sci((cmd_op_i == OP_MVOLT) ? meas_volt_i : meas_curr_i);
          d.resp_neg = (cmd_op_i == OP_MVOLT) ? meas_volt_neg_i : meas_curr_neg_i;
        end
        OP_MTRAN: begin
          if (tran_count_i != 4'h0) begin
            d.tran_busy = 1'b1;
            d.tran_idx = 4'h0;
          end
        end
        OP_RST: begin
          d.fsm = ST_IDLE;
        end
        OP_VPROT: begin
          if (cmd_kw_i == KW_MAX) begin
            d.vprot_pos = VPROT_FS;
            d.vprot_neg = VPROT_FS; // negative side, sign implied
          end else if (val_ok) begin
            d.vprot_pos = val.mag;
            d.vprot_neg = val.mag;
          end else begin
            d.err_valid = 1'b1;
            d.err_code = val_err;
          end
        end
        default: begin
        end
      endcase
    end
    // transient samples stream one per cycle, last one marked
    if (q.tran_busy) begin
      d.resp_valid = 1'b1;
      {d.resp_mant, d.resp_exp} = to_sci(tran_sample_i[q.tran_idx[2:0]]);
      d.resp_neg = tran_neg_i[q.tran_idx[2:0]];
      d.tran_idx = q.tran_idx + 4'h1;
      if (d.tran_idx >= tran_count_i || d.tran_idx >= TRAN_MAX) begin
        d.tran_busy = 1'b0;
        d.resp_last = 1'b1;
      end
    end
    // waiting flag follows the arm state; external fire drops it one cycle
    d.wtg = (d.fsm == ST_ARMED)
            || (d.fsm == ST_CONT && !(fire && q.src_ext));
    // set wins over the clear
    d.evt_wtg = ((d.wtg != q.wtg) && oper_en_i[WTG_BIT])
                || (q.evt_wtg && !oper_evt_clr_i);
  end

  // reset puts the rate at its normal 60 Hz and disarms
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.rate <= RATE_60;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state
  always_comb begin
    oper_cond_o = '0;
    oper_cond_o[WTG_BIT] = q.wtg;
    oper_event_o = '0;
    oper_event_o[WTG_BIT] = q.evt_wtg;
  end
  assign volt_set_o = q.volt_set;
  assign curr_set_o = q.curr_set;
  assign vprot_pos_o = q.vprot_pos;
  assign vprot_neg_o = q.vprot_neg;
  assign trig_pulse_o = q.trig_pulse;
  assign meas_rate_o = q.rate;
  assign resp_valid_o = q.resp_valid;
  assign resp_mant_o = q.resp_mant;
  assign resp_exp_o = q.resp_exp;
  assign resp_neg_o = q.resp_neg;
  assign resp_is_int_o = q.resp_is_int;
  assign resp_int_o = q.resp_int;
  assign resp_last_o = q.resp_last;
  assign err_valid_o = q.err_valid;
  assign err_code_o = q.err_code;

  AST_ABORT_DISARM:
  assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take && cmd_op_i == OP_ABORT && q.fsm == ST_ARMED |=> q.fsm == ST_IDLE && !oper_cond_o[5])
    else $error("abort left single arm pending");

  AST_ABORT_CONT:
  assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take && cmd_op_i == OP_ABORT && q.fsm == ST_CONT |=> q.fsm == ST_CONT)
    else $error("abort changed continuous arming");

  AST_TRIG_APPLY:
  assert property (@(posedge clk_i) disable iff (sys_rst_i)
    fire |=> volt_set_o == $past(q.vtrig) && curr_set_o == $past(q.ctrig) && trig_pulse_o)
    else $error("trigger did not apply stored levels");

  AST_SINGLE_ONCE:
  assert property (@(posedge clk_i) disable iff (sys_rst_i)
    fire && q.fsm == ST_ARMED && !(take && cmd_op_i inside {OP_INIT, OP_CONT})
    |=> q.fsm == ST_IDLE ##1 !fire || q.fsm != ST_IDLE)
    else $error("single arm accepted a second trigger");

  AST_CONT_BUS_WTG:
  assert property (@(posedge clk_i) disable iff (sys_rst_i)
    q.fsm == ST_CONT && !q.src_ext |-> oper_cond_o[5])
    else $error("waiting flag low in continuous bus mode");

  AST_EXT_DROP:
  assert property (@(posedge clk_i) disable iff (sys_rst_i)
    fire && q.fsm == ST_CONT && q.src_ext && !take |=> !oper_cond_o[5] ##1 oper_cond_o[5])
    else $error("waiting flag did not pulse low on external trigger");

  AST_EVENT_LATCH:
  assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $changed(oper_cond_o[5]) && $past(oper_en_i[5]) |-> oper_event_o[5])
    else $error("waiting flag transition not latched");

  AST_RST_CMD:
  assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take && cmd_op_i == OP_RST |=> q.fsm == ST_IDLE && !oper_cond_o[5])
    else $error("reset command left arming on");

  AST_CONT_QUERY:
  assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take && cmd_op_i == OP_CONTQ |=> resp_valid_o && resp_is_int_o
    && resp_int_o == ($past(q.fsm) == ST_CONT))
    else $error("continuous query answered wrongly");

  AST_RATE_LEGAL:
  assert property (@(posedge clk_i) disable iff (sys_rst_i)
    meas_rate_o == RATE_50 || meas_rate_o == RATE_60 || meas_rate_o == RATE_125)
    else $error("illegal measurement rate held");

  AST_REJECT_KEEP:
  assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take && cmd_op_i == OP_VTRIG && !val_ok |=> err_valid_o && $stable(q.vtrig))
    else $error("rejected argument changed the setting");

  COV_SINGLE_FIRE: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    fire && q.fsm == ST_ARMED);
  COV_EXT_CONT: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    fire && q.fsm == ST_CONT && q.src_ext);
  COV_RANGE_ERR: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    err_valid_o && err_code_o == ERR_NUMERIC);
  COV_TRAN_FULL: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    resp_last_o && q.tran_idx == TRAN_MAX);

endmodule
`default_nettype wire

// ### rtl/trig_cmd_pkg.sv
// shared constants and types of the trigger command front end
// assumes numeric magnitudes are carried in units of 1e-8
package trig_cmd_pkg;

  // numeric argument limits
  localparam int INT_DIGITS = 4;
  localparam int FRAC_DIGITS = 8;
  localparam int MAG_W = 41;
  localparam logic [40:0] MAG_SCALE = 41'h0_05F5_E100; // 1.0 in magnitude units
  localparam logic [40:0] DEC_BASE = 41'h000A;
  localparam logic [40:0] MAG_MAX = 41'h97_5CFA_9DF0; // 6500.9999
  localparam logic [40:0] MAG_MIN = 41'h0064; // .000001
  localparam logic [7:0] MAX_STR_LEN = 8'hFD; // 253 characters
  localparam logic [7:0] LEN_SAT = 8'hFF;

  // character codes seen by the argument parser
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_PT = 8'h2E;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_END = 8'h0A;

  // error codes queued to the host
  localparam logic [7:0] ERR_NUMERIC = 8'h78; // 120
  localparam logic [7:0] ERR_MISSING = 8'h6D; // 109
  localparam logic [7:0] ERR_TOO_LONG = 8'hDF; // 223

  // status and measurement settings
  localparam int WTG_BIT = 5;
  localparam logic [6:0] RATE_50 = 7'h32;
  localparam logic [6:0] RATE_60 = 7'h3C;
  localparam logic [6:0] RATE_125 = 7'h7D;
  localparam logic [3:0] TRAN_MAX = 4'h8;
  localparam logic [4:0] EXP_LEAD = 5'h03; // exponent of the leading integer digit

  typedef enum logic [3:0] {
    OP_NONE = 4'b0000, OP_VTRIG = 4'b0001, OP_CTRIG = 4'b0010, OP_ABORT = 4'b0011,
    OP_INIT = 4'b0100, OP_CONT = 4'b0101, OP_CONTQ = 4'b0110, OP_TRG = 4'b0111,
    OP_SOUR = 4'b1000, OP_RATE = 4'b1001, OP_MVOLT = 4'b1010, OP_MCURR = 4'b1011,
    OP_MTRAN = 4'b1100, OP_RST = 4'b1101, OP_VPROT = 4'b1110
  } op_t;

  typedef enum logic [1:0] {KW_NONE = 2'b00, KW_MAX = 2'b01, KW_MIN = 2'b10} kw_t;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ARMED = 2'b01, ST_CONT = 2'b10} fsm_t;

  typedef struct packed {
    logic neg;
    logic [40:0] mag;
  } num_t;

endpackage
